// ===== mip_pkg.sv
/*
 * constants and types for the microcontroller port block: register
 * offsets, field positions, reset values and timing counts.
 * assumes an APB master on the system clock.
 */
package mip_pkg;
    // ========================================================
    // register byte offsets
    localparam logic [7:0] OFS_UPPER_DATA = 8'h00; // upper port data
    localparam logic [7:0] OFS_GP_DATA    = 8'h04; // general port data
    localparam logic [7:0] OFS_CTL_DATA   = 8'h08; // control port data
    localparam logic [7:0] OFS_UPPER_MODE = 8'h0C; // upper port mode
    localparam logic [7:0] OFS_GP_DIR     = 8'h10; // general dir, 1=in
    localparam logic [7:0] OFS_CTL_MODE   = 8'h14; // control port mode
    localparam logic [7:0] OFS_BUS_CMD    = 8'h18; // external cycle
    localparam logic [7:0] OFS_BUS_STAT   = 8'h1C; // cycle status
    // ========================================================
    // upper mode fields
    localparam int UM_LO_ADDR = 0; // low nibble drives A8-A11
    localparam int UM_HI_ADDR = 1; // high nibble drives A12-A15
    localparam int UM_HI_IN   = 2; // high nibble input when I/O
    localparam int UM_LO_IN   = 3; // low nibble input when I/O
    localparam int UM_EXT_TIM = 4; // extended bus timing
    // control mode fields
    localparam int CM_HS_UP  = 0; // upper port handshake
    localparam int CM_HS_GP  = 1; // general port handshake
    localparam int CM_SERIAL = 2; // serial on lines 0 and 7
    localparam int CM_DSEL   = 3; // line 4 is data space select
    localparam int CM_TOUT   = 4; // line 6 timer output
    localparam int CM_TSEL   = 5; // [6:5] 0=t0 1=t1 2=clock
    localparam int CM_ODRAIN = 7; // general port open drain
    localparam int CM_TINM   = 8; // [9:8] timer input mode
    // bus command fields
    localparam int BC_WRITE = 8;  // 1=write cycle
    localparam int BC_DATA  = 9;  // 1=data memory space
    localparam int BC_ADDR  = 16; // [31:16] address
    // reset values
    localparam logic [4:0] UMODE_FLOAT = 5'h1C; // inputs, extended
    localparam logic [4:0] UMODE_ADDR  = 5'h03; // address, fast
    localparam logic [7:0] GPDIR_RST   = 8'hFF;
    // timing: wait of two oscillator clocks
    localparam int WAIT_CLKS = 2;
    // ========================================================
    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b000,
        BUS_ADDR  = 3'b001,
        BUS_LATCH = 3'b010,
        BUS_WAIT  = 3'b011,
        BUS_XFER  = 3'b100,
        BUS_END   = 3'b101
    } mip_bus_t;
endpackage

// ===== mip_io_ports.sv
/*
 * io ports and multiplexed external memory port of a romless
 * microcontroller, with an APB register slave.
 * assumes pins arrive asynchronously and pass two flip-flops; the
 * timers, uart and interrupt controller sit outside and meet this
 * block through plain ports.
 */
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module mip_io_ports #(
    parameter bit FLOAT_VARIANT = 1'b1 // 1: floating, extended start
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  memAdIn,
    output logic      [7:0]  memAdOut,
    output logic      [7:0]  memAdOe,
    output logic             address_strobe_n,
    output logic             data_strobe_n,
    output logic             readWrite,
    input  wire logic [7:0]  upperIn,
    output logic      [7:0]  upperOut,
    output logic      [7:0]  upperOe,
    input  wire logic [7:0]  gpIn,
    output logic      [7:0]  gpOut,
    output logic      [7:0]  gpOe,
    input  wire logic [3:0]  ctlIn,
    output logic      [7:0]  ctlOut,
    output logic      [3:0]  external_irq_inputs,
    output logic             serialRxData,
    input  wire logic        serialTxData,
    output logic             timerInput,
    output logic      [1:0]  timerInputMode,
    input  wire logic        timer0Out,
    input  wire logic        timer1Out,
    input  wire logic        internalClk,
    input  wire logic        upperStrobeSet,
    input  wire logic        gpStrobeSet
);
    // ========================================================
    // reset release and pin synchronisers
    logic [1:0]  rstSync;     // reset release chain
    logic        rstn;        // synchronous copy of reset
    logic [7:0]  adS1, adS2;  // memory port input
    logic [7:0]  upS1, upS2;  // upper port input
    logic [7:0]  gpS1, gpS2;  // general port input
    logic [3:0]  ctS1, ctS2;  // control port input

    // reset leaves through two flip-flops
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            rstSync <= 2'h0;
        else
            rstSync <= {rstSync[0], 1'b1};
    end
    assign rstn = rstSync[1];

    // two-stage sampling of every pin input
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            adS1 <= 8'h00; adS2 <= 8'h00;
            upS1 <= 8'h00; upS2 <= 8'h00;
            gpS1 <= 8'h00; gpS2 <= 8'h00;
            ctS1 <= 4'h0;  ctS2 <= 4'h0;
        end
        else
        begin
            adS1 <= memAdIn; adS2 <= adS1;
            upS1 <= upperIn; upS2 <= upS1;
            gpS1 <= gpIn;    gpS2 <= gpS1;
            ctS1 <= ctlIn;   ctS2 <= ctS1;
        end
    end

    // ========================================================
    // register state
    logic [7:0]  upData, gpData, ctlData;      // port output latches
    logic [4:0]  upMode;                       // upper port mode
    logic [7:0]  gpDir;                        // 1 = input
    logic [9:0]  ctlMode;                      // control port mode
    logic [7:0]  next_upData, next_gpData, next_ctlData;
    logic [4:0]  next_upMode;
    logic [7:0]  next_gpDir;
    logic [9:0]  next_ctlMode;
    logic        wrEn, rdEn;                   // access phase strobes
    logic        cmdWr;                        // bus cycle request

    assign wrEn  = psel && penable && pwrite;
    assign rdEn  = psel && penable && !pwrite;
    assign cmdWr = wrEn && (paddr == mip_pkg::OFS_BUS_CMD);

    // register writes, address decoded by priority chain
    always_comb
    begin
        next_upData  = upData;
        next_gpData  = gpData;
        next_ctlData = ctlData;
        next_upMode  = upMode;
        next_gpDir   = gpDir;
        next_ctlMode = ctlMode;
        if (wrEn)
        begin
            if (paddr == mip_pkg::OFS_UPPER_DATA)
                next_upData = pwdata[7:0];
            else if (paddr == mip_pkg::OFS_GP_DATA)
                next_gpData = pwdata[7:0];
            else if (paddr == mip_pkg::OFS_CTL_DATA)
                next_ctlData = pwdata[7:0];
            else if (paddr == mip_pkg::OFS_UPPER_MODE)
                next_upMode = pwdata[4:0];
            else if (paddr == mip_pkg::OFS_GP_DIR)
                next_gpDir = pwdata[7:0];
            else if (paddr == mip_pkg::OFS_CTL_MODE)
                next_ctlMode = pwdata[9:0];
        end
    end

    // register file, reset depends on variant
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            upData  <= 8'h00;
            gpData  <= 8'h00;
            ctlData <= 8'h00;
            // float variant: inputs with waits; other: address, fast
            upMode  <= FLOAT_VARIANT ? mip_pkg::UMODE_FLOAT
                                     : mip_pkg::UMODE_ADDR;
            gpDir   <= mip_pkg::GPDIR_RST;
            ctlMode <= 10'h000;
        end
        else
        begin
            upData  <= next_upData;
            gpData  <= next_gpData;
            ctlData <= next_ctlData;
            upMode  <= next_upMode;
            gpDir   <= next_gpDir;
            ctlMode <= next_ctlMode;
        end
    end

    // ========================================================
    // external memory cycle engine
    mip_pkg::mip_bus_t state, next_state;
    logic [15:0] cAddr, next_cAddr;   // cycle address
    logic [7:0]  cData, next_cData;   // write data / read result
    logic        cWr, next_cWr;       // write cycle
    logic        cDsp, next_cDsp;     // data space cycle
    logic [1:0]  wCnt, next_wCnt;     // wait counter
    logic        busBusy;

    assign busBusy = (state != mip_pkg::BUS_IDLE);

    // sequence: address out, strobe, data strobe stretched by optional waits
    always_comb
    begin
        next_state = state;
        next_cAddr = cAddr;
        next_cData = cData;
        next_cWr   = cWr;
        next_cDsp  = cDsp;
        next_wCnt  = wCnt;
        case (state)
            mip_pkg::BUS_IDLE:
            begin
                if (cmdWr)
                begin
                    next_cAddr = pwdata[31:16];
                    next_cData = pwdata[7:0];
                    next_cWr   = pwdata[mip_pkg::BC_WRITE];
                    next_cDsp  = pwdata[mip_pkg::BC_DATA];
                    next_state = mip_pkg::BUS_ADDR;
                end
            end
            mip_pkg::BUS_ADDR:
                next_state = mip_pkg::BUS_LATCH;   // strobe low
            mip_pkg::BUS_LATCH:
            begin
                next_wCnt  = 2'(mip_pkg::WAIT_CLKS);
                next_state = upMode[mip_pkg::UM_EXT_TIM] ?
                             mip_pkg::BUS_WAIT : mip_pkg::BUS_XFER;
            end
            mip_pkg::BUS_WAIT:
            begin
                next_wCnt = wCnt - 2'h1;
                if (wCnt == 2'h1)
                    next_state = mip_pkg::BUS_XFER;
            end
            mip_pkg::BUS_XFER:
            begin
                if (!cWr)
                    next_cData = adS2;             // read sample
                next_state = mip_pkg::BUS_END;
            end
            mip_pkg::BUS_END:
                next_state = mip_pkg::BUS_IDLE;
            default:
                next_state = mip_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= mip_pkg::BUS_IDLE;
            cAddr <= 16'h0000;
            cData <= 8'h00;
            cWr   <= 1'b0;
            cDsp  <= 1'b0;
            wCnt  <= 2'h0;
        end
        else
        begin
            state <= next_state;
            cAddr <= next_cAddr;
            cData <= next_cData;
            cWr   <= next_cWr;
            cDsp  <= next_cDsp;
            wCnt  <= next_wCnt;
        end
    end

    // memory port pins from flip-flops
    logic [7:0] next_memAdOut, next_memAdOe;
    logic       next_as, next_ds, next_rw;
    always_comb
    begin
        // low address byte always driven when idle
        next_memAdOut = next_cAddr[7:0];
        next_memAdOe  = 8'hFF;
        next_as = !(next_state == mip_pkg::BUS_LATCH);
        next_ds = !((next_state == mip_pkg::BUS_WAIT) ||
                    (next_state == mip_pkg::BUS_XFER));
        next_rw = !(next_cWr && busBusy);
        if ((next_state == mip_pkg::BUS_WAIT) ||
            (next_state == mip_pkg::BUS_XFER))
        begin
            // data phase: write drives data, read releases
            next_memAdOut = next_cData;
            next_memAdOe  = next_cWr ? 8'hFF : 8'h00;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            memAdOut         <= 8'h00;
            memAdOe          <= 8'hFF;
            address_strobe_n <= 1'b1;
            data_strobe_n    <= 1'b1;
            readWrite        <= 1'b1;
        end
        else
        begin
            memAdOut         <= next_memAdOut;
            memAdOe          <= next_memAdOe;
            address_strobe_n <= next_as;
            data_strobe_n    <= next_ds;
            readWrite        <= next_rw;
        end
    end

    // ========================================================
    // upper, general and control port pins
    logic [7:0] upOutC, upOeC, gpOutC, gpOeC, ctlOutC;
    logic       upHiIn, gpHiIn;
    logic [1:0] tsel;
    logic       toutSig;

    assign upHiIn = upMode[mip_pkg::UM_HI_IN];
    assign gpHiIn = gpDir[7];
    assign tsel   = ctlMode[mip_pkg::CM_TSEL+1:mip_pkg::CM_TSEL];

    always_comb
    begin
        // nibble select between address and port latch
        upOutC = upData;
        upOeC  = {{4{!upHiIn}}, {4{!upMode[mip_pkg::UM_LO_IN]}}};
        if (upMode[mip_pkg::UM_LO_ADDR])
        begin
            upOutC[3:0] = cAddr[11:8];
            upOeC[3:0]  = 4'hF;
        end
        if (upMode[mip_pkg::UM_HI_ADDR])
        begin
            upOutC[7:4] = cAddr[15:12];
            upOeC[7:4]  = 4'hF;
        end
        // per-bit direction, open drain drives only lows
        gpOutC = gpData;
        gpOeC  = ~gpDir;
        if (ctlMode[mip_pkg::CM_ODRAIN])
        begin
            gpOutC = 8'h00;
            gpOeC  = ~gpDir & ~gpData;
        end
        // timer output source
        case (tsel)
            2'h0:    toutSig = timer0Out;
            2'h1:    toutSig = timer1Out;
            default: toutSig = internalClk;
        endcase
        // control outputs 0-3 fixed low, functions override latch on 4-7
        ctlOutC = {ctlData[7:4], 4'h0};
        if (ctlMode[mip_pkg::CM_DSEL])
            ctlOutC[4] = !(cDsp && busBusy);
        if (ctlMode[mip_pkg::CM_TOUT])
            ctlOutC[6] = toutSig;
        if (ctlMode[mip_pkg::CM_SERIAL])
            ctlOutC[7] = serialTxData;
        // upper port handshake output, role by upper nibble direction
        if (ctlMode[mip_pkg::CM_HS_UP])
            if (upHiIn) ctlOutC[5] = upperStrobeSet;     // ready
            else        ctlOutC[5] = !upperStrobeSet;    // available
        // general port handshake role by bit 7 direction
        if (ctlMode[mip_pkg::CM_HS_GP] && !ctlMode[mip_pkg::CM_TOUT])
            if (gpHiIn) ctlOutC[6] = gpStrobeSet;
            else        ctlOutC[6] = !gpStrobeSet;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            upperOut <= 8'h00;
            upperOe  <= 8'h00;
            gpOut    <= 8'h00;
            gpOe     <= 8'h00;
            ctlOut   <= 8'h00;
        end
        else
        begin
            upperOut <= upOutC;
            upperOe  <= upOeC;
            gpOut    <= gpOutC;
            gpOe     <= gpOeC;
            ctlOut   <= ctlOutC;
        end
    end

    // control inputs to irq, serial and timer functions
    assign external_irq_inputs = ctS2;
    assign serialRxData   = ctlMode[mip_pkg::CM_SERIAL] ? ctS2[0] : 1'b1;
    assign timerInput     = ctS2[1];
    assign timerInputMode = ctlMode[mip_pkg::CM_TINM+1:mip_pkg::CM_TINM];

    // ========================================================
    // APB read side, zero wait states
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (paddr == mip_pkg::OFS_UPPER_DATA)
            prdata[7:0] = upS2;
        else if (paddr == mip_pkg::OFS_GP_DATA)
            prdata[7:0] = (gpS2 & gpDir) | (gpData & ~gpDir);
        else if (paddr == mip_pkg::OFS_CTL_DATA)
            prdata[7:0] = {ctlData[7:4], ctS2};
        else if (paddr == mip_pkg::OFS_UPPER_MODE)
            prdata[4:0] = upMode;
        else if (paddr == mip_pkg::OFS_GP_DIR)
            prdata[7:0] = gpDir;
        else if (paddr == mip_pkg::OFS_CTL_MODE)
            prdata[9:0] = ctlMode;
        else if (paddr == mip_pkg::OFS_BUS_STAT)
            prdata[8:0] = {busBusy, cData};
    end
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (paddr[1:0] != 2'h0 ||
                     paddr > mip_pkg::OFS_BUS_STAT ||
                     (cmdWr && busBusy));

    // ========================================================
    // checks
    a_as_pulse_one: assert property (@(posedge sys_clk) disable iff (!rstn)
        $fell(address_strobe_n) |=> address_strobe_n)
        else $error("address strobe longer than one cycle");
    a_ds_after_as: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(address_strobe_n) |-> ##[0:2] !data_strobe_n)
        else $error("data strobe missing after address strobe");
    a_ext_wait: assert property (@(posedge sys_clk) disable iff (!rstn)
        ($rose(address_strobe_n) && upMode[mip_pkg::UM_EXT_TIM])
        |-> !data_strobe_n [*3])
        else $error("extended data strobe not three cycles");
    a_rw_write: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!data_strobe_n && cWr) |-> !readWrite)
        else $error("write without read/write low");
    a_gp_od: assert property (@(posedge sys_clk) disable iff (!rstn)
        ctlMode[mip_pkg::CM_ODRAIN] |=> (gpOut == 8'h00))
        else $error("open drain drives high");
    a_rd_release: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!data_strobe_n && readWrite) |-> (memAdOe == 8'h00))
        else $error("memory port driven during read data phase");
    c_write: cover property (@(posedge sys_clk) !data_strobe_n && cWr);
    c_read: cover property (@(posedge sys_clk) !data_strobe_n && !cWr);
    c_ext: cover property (@(posedge sys_clk)
        !data_strobe_n && upMode[mip_pkg::UM_EXT_TIM]);
endmodule

// ===== mip_mem_model.sv
/*
 * external memory on the multiplexed memory port: latches the address
 * at the address strobe's falling edge, stores write data, answers
 * reads.
 * assumes the strobes and port lines of mip_io_ports, one clock.
 */
`timescale 1ns/1ps
module mip_mem_model (
    input  wire logic       address_strobe_n,
    input  wire logic       data_strobe_n,
    input  wire logic       readWrite,
    input  wire logic [7:0] memAdOut,
    input  wire logic [7:0] upperOut,
    input  wire logic       dataSel,
    output logic      [7:0] memAdIn
);
    // ========================================================
    // storage and latched address
    logic [7:0] mem [256];  // byte store, low address only
    logic [7:0] addrLo;     // latched low address
    logic [7:0] addrHi;     // latched upper address
    logic       selSeen;    // data select at latch time
    logic       driveOn;    // read data on the lines
    logic [7:0] lastVal;    // last value driven

    initial
    begin
        addrLo  = 8'h00;
        addrHi  = 8'h00;
        selSeen = 1'b1;
        driveOn = 1'b0;
        lastVal = 8'h00;
        wrData  = 8'h00;
        wrSeen  = 1'b0;
    end

    logic [7:0] wrData;     // write data seen in data phase
    logic       wrSeen;     // cycle is a write

    // address stands through the strobe; taken once it has settled,
    // clear of the edge where the lines turn to data
    always @(negedge address_strobe_n)
    begin
        #1;
        addrLo  = memAdOut;
        addrHi  = upperOut;
        selSeen = dataSel;
        driveOn = readWrite;
    end

    // write data taken just after the data strobe falls
    always @(negedge data_strobe_n)
    begin
        #1;
        wrData = memAdOut;
        wrSeen = !readWrite;
    end

    // write lands when data strobe ends
    always @(posedge data_strobe_n)
    begin
        if (wrSeen)
            mem[addrLo] = wrData;
        wrSeen  = 1'b0;
        driveOn = 1'b0;
    end

    // released lines show inverse of last value
    always_comb
    begin
        if (driveOn)
            memAdIn = mem[address_strobe_n ? addrLo : memAdOut];
        else
            memAdIn = ~lastVal;
    end
    always @(memAdIn)
        if (driveOn)
            lastVal = memAdIn;
endmodule

// ===== test_mip_io_ports.sv
/*
 * self-checking bench for the port block: reset state, external
 * memory cycles, upper, general and control ports.
 * assumes zero-wait APB slave and the memory model.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin \
    miscompares++; $display("[ERR] %0t got %0h exp %0h", $time, a, b); \
    end end
module test_mip_io_ports;
    // ========================================================
    // signals
    logic sys_clk = 1'b0, resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er;
    logic [7:0] memAdIn, memAdOut, memAdOe, upperOut, upperOe;
    logic [7:0] upperIn = 8'h00, gpIn = 8'h00, gpOut, gpOe, ctlOut;
    logic [3:0] ctlIn = 4'h0, irqs;
    logic address_strobe_n, data_strobe_n, readWrite;
    logic serialRxData, timerInput, serialTxData = 1'b1;
    logic [1:0] timerInputMode;
    logic timer0Out = 1'b0, timer1Out = 1'b1, internalClk = 1'b1;
    int miscompares = 0, samplesChecked = 0;
    int dsRun = 0, dsWidth = 0, asCount = 0;

    always #5 sys_clk = ~sys_clk;

    mip_io_ports #(.FLOAT_VARIANT(1'b1)) dut (.sys_clk(sys_clk),
        .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .memAdIn(memAdIn), .memAdOut(memAdOut),
        .memAdOe(memAdOe), .address_strobe_n(address_strobe_n),
        .data_strobe_n(data_strobe_n), .readWrite(readWrite),
        .upperIn(upperIn), .upperOut(upperOut), .upperOe(upperOe),
        .gpIn(gpIn), .gpOut(gpOut), .gpOe(gpOe), .ctlIn(ctlIn),
        .ctlOut(ctlOut), .external_irq_inputs(irqs),
        .serialRxData(serialRxData), .serialTxData(serialTxData),
        .timerInput(timerInput), .timerInputMode(timerInputMode),
        .timer0Out(timer0Out), .timer1Out(timer1Out),
        .internalClk(internalClk), .upperStrobeSet(1'b0),
        .gpStrobeSet(1'b0));

    mip_mem_model mem_u (.address_strobe_n(address_strobe_n),
        .data_strobe_n(data_strobe_n), .readWrite(readWrite),
        .memAdOut(memAdOut), .upperOut(upperOut), .dataSel(ctlOut[4]),
        .memAdIn(memAdIn));

    // strobe width and pulse counting
    always @(posedge sys_clk)
    begin
        if (data_strobe_n === 1'b0)
            dsRun <= dsRun + 1;
        else if (dsRun != 0)
        begin
            dsWidth <= dsRun;
            dsRun   <= 0;
        end
        if (address_strobe_n === 1'b0)
            asCount <= asCount + 1;
    end

    // ========================================================
    // bus tasks
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge sys_clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // one external cycle, polled until idle
    task automatic run(input logic [15:0] a, input logic w,
                       input logic dsp, input logic [7:0] d);
        int n;
        n = 0;
        apb(1'b1, mip_pkg::OFS_BUS_CMD, {a, 6'h0, dsp, w, d});
        do
        begin
            apb(1'b0, mip_pkg::OFS_BUS_STAT, 32'h0);
            n++;
        end while (rd[8] !== 1'b0 && n < 40);
        `CHK(rd[8], 1'b0)
    endtask

    // ========================================================
    // scenarios
    task automatic t_reset;
        `CHK(memAdOe, 8'hFF)
        `CHK(upperOe, 8'h00)
        `CHK(ctlOut[3:0], 4'h0)
        apb(1'b0, mip_pkg::OFS_UPPER_MODE, 32'h0);
        `CHK(rd[4:0], mip_pkg::UMODE_FLOAT)
        apb(1'b0, 8'h20, 32'h0);
        `CHK(er, 1'b1)
        $display("test reset done");
    endtask

    task automatic t_memory;
        int a0;
        a0 = asCount;
        run(16'h0055, 1'b1, 1'b0, 8'hA5);
        `CHK(mem_u.mem[8'h55], 8'hA5)
        `CHK(dsWidth, mip_pkg::WAIT_CLKS + 1)
        `CHK(asCount - a0, 1)
        run(16'h0055, 1'b0, 1'b0, 8'h00);
        `CHK(rd[7:0], 8'hA5)
        $display("test memory done");
    endtask

    task automatic t_upper;
        apb(1'b1, mip_pkg::OFS_UPPER_DATA, 32'h12);
        apb(1'b1, mip_pkg::OFS_UPPER_MODE, 32'h03);
        repeat (2) @(posedge sys_clk);
        `CHK(upperOe, 8'hFF)
        run(16'h3456, 1'b1, 1'b0, 8'h77);
        `CHK(mem_u.addrHi, 8'h34)
        `CHK(dsWidth, 1)
        apb(1'b1, mip_pkg::OFS_UPPER_DATA, 32'hA0);
        apb(1'b1, mip_pkg::OFS_UPPER_MODE, 32'h01);
        repeat (2) @(posedge sys_clk);
        `CHK(upperOut[7:4], 4'hA)
        $display("test upper done");
    endtask

    task automatic t_gp;
        gpIn <= 8'h3C;
        apb(1'b1, mip_pkg::OFS_GP_DIR, 32'h0F);
        apb(1'b1, mip_pkg::OFS_GP_DATA, 32'h5A);
        repeat (3) @(posedge sys_clk);
        `CHK(gpOe, 8'hF0)
        `CHK(gpOut[7:4], 4'h5)
        apb(1'b0, mip_pkg::OFS_GP_DATA, 32'h0);
        `CHK(rd[3:0], 4'hC)
        apb(1'b1, mip_pkg::OFS_CTL_MODE, 32'h80);
        repeat (2) @(posedge sys_clk);
        `CHK(gpOe, 8'hA0)
        $display("test general done");
    endtask

    task automatic t_ctl;
        apb(1'b1, mip_pkg::OFS_CTL_MODE, 32'h300);
        apb(1'b1, mip_pkg::OFS_CTL_DATA, 32'hAF);
        ctlIn <= 4'hA;
        repeat (4) @(posedge sys_clk);
        `CHK(ctlOut, 8'hA0)
        `CHK(irqs, 4'hA)
        `CHK(timerInput, 1'b1)
        `CHK(timerInputMode, 2'h3)
        apb(1'b1, mip_pkg::OFS_CTL_MODE, 32'h54);
        ctlIn <= 4'h6;
        serialTxData <= 1'b0;
        repeat (4) @(posedge sys_clk);
        `CHK(serialRxData, 1'b0)
        `CHK(ctlOut[7], 1'b0)
        `CHK(ctlOut[6], internalClk)
        apb(1'b1, mip_pkg::OFS_CTL_MODE, 32'h3C);
        repeat (2) @(posedge sys_clk);
        `CHK(ctlOut[6], timer1Out)
        apb(1'b1, mip_pkg::OFS_CTL_MODE, 32'h0B);
        repeat (2) @(posedge sys_clk);
        `CHK(ctlOut[5], 1'b1)
        `CHK(ctlOut[6], 1'b1)
        run(16'h0011, 1'b0, 1'b1, 8'h00);
        `CHK(mem_u.selSeen, 1'b0)
        $display("test control done");
    endtask

    // ========================================================
    // verdict and run order
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", samplesChecked,
                 miscompares);
        if (miscompares == 0 && samplesChecked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #200000;
        miscompares++;
        wrap_up();
    end

    initial
    begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_reset();
        t_memory();
        t_upper();
        t_gp();
        t_ctl();
        wrap_up();
    end
endmodule
